/* flex_port_asserts.sv */
// concurrent checks on the pins between the converter end and the back end
`timescale 1ns/1ns
module flex_port_asserts
    import flex_port_pkg::*;
(
    input wire logic i_link_clk,
    input wire logic i_reset_n,
    input wire logic [BUS_W-1:0] upper_dev_oe,
    input wire logic [BUS_W-1:0] lower_dev_oe,
    input wire logic [BUS_W-1:0] upper_host_oe,
    input wire logic [BUS_W-1:0] lower_host_oe,
    input wire logic [BUS_W-1:0] upper_bus,
    input wire logic [BUS_W-1:0] lower_bus,
    input wire logic width_dev_o,
    input wire logic width_dev_oe,
    input wire logic width_host_oe,
    input wire logic path_clock_out_pin
);
    logic [3:0] rst_pipe;
    // both ends leave reset two link edges late and first toggle one edge after that
    wire link_ok = i_reset_n && rst_pipe[3];

    always_ff @(posedge i_link_clk) begin
        rst_pipe <= {rst_pipe[2:0], i_reset_n};
    end

    default clocking cb @(posedge i_link_clk);
    endclocking
    default disable iff (!link_ok);

    property p_wide_rx_both;
        upper_dev_oe == BUS_ALL |-> lower_dev_oe == BUS_ALL;
    endproperty
    a_wide_rx_both: assert property (p_wide_rx_both) else $error("wide receive uses one bus");
    property p_wide_rx_hold;
        upper_dev_oe == BUS_ALL && $rose(path_clock_out_pin)
            |=> $stable(upper_bus) && $stable(lower_bus);
    endproperty
    a_wide_rx_hold: assert property (p_wide_rx_hold) else $error("wide word left early");
    property p_narrow_rx_marker;
        upper_dev_oe == BUS_MSB |-> lower_dev_oe == BUS_ALL
            && upper_bus[MARKER_BIT] == path_clock_out_pin;
    endproperty
    a_narrow_rx_marker: assert property (p_narrow_rx_marker)
        else $error("receive marker wrong");
    property p_path_clock_rate;
        $rose(path_clock_out_pin) |=> $fell(path_clock_out_pin) ##1 $rose(path_clock_out_pin);
    endproperty
    a_path_clock_rate: assert property (p_path_clock_rate)
        else $error("path clock not halving");
    property p_sysclk_runs;
        width_dev_oe && $past(width_dev_oe) |-> width_dev_o != $past(width_dev_o);
    endproperty
    a_sysclk_runs: assert property (p_sysclk_runs) else $error("system clock copy stuck");
    property p_width_one_driver;
        !(width_dev_oe && width_host_oe);
    endproperty
    a_width_one_driver: assert property (p_width_one_driver)
        else $error("second pin driven twice");
    property p_narrow_tx_marker;
        lower_host_oe == BUS_MSB |-> upper_host_oe == BUS_ALL && lower_dev_oe == BUS_NONE;
    endproperty
    a_narrow_tx_marker: assert property (p_narrow_tx_marker)
        else $error("transmit layout wrong");
    // a short grace lets the config crossing settle after reset
    property p_fd_rx_lower;
        upper_host_oe == BUS_ALL && lower_host_oe == BUS_NONE
            |-> ##[0:3] lower_dev_oe == BUS_ALL && upper_dev_oe == BUS_NONE;
    endproperty
    a_fd_rx_lower: assert property (p_fd_rx_lower) else $error("full duplex receive missing");
endmodule

/* flex_port_device.sv */
// converter end of the dual-bus data port, plus the word crossing used by both ends
`timescale 1ns/1ns

module word_mailbox
    import flex_port_pkg::*;
(
    input wire logic i_src_clk,
    input wire logic i_src_rst_n,
    input wire logic i_valid,
    input wire logic [PAIR_W-1:0] i_data,
    output logic o_ready,
    input wire logic i_dst_clk,
    input wire logic i_dst_rst_n,
    output logic o_valid,
    output logic [PAIR_W-1:0] o_data
);
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [PAIR_W-1:0] held;
    logic req_s1;
    logic req_s2;
    logic ack;
    wire take = req_s2 != ack;

    // toggle handshake; held stays still until the far side has acknowledged
    assign o_ready = req == ack_s2;

    always_ff @(posedge i_src_clk) begin
        if (!i_src_rst_n) begin
            req <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            held <= PAIR_RESET;
        end else begin
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
            if (i_valid && o_ready) begin
                held <= i_data;
                req <= ~req;
            end
        end
    end

    always_ff @(posedge i_dst_clk) begin
        if (!i_dst_rst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack <= 1'b0;
            o_valid <= 1'b0;
            o_data <= PAIR_RESET;
        end else begin
            req_s1 <= req;
            req_s2 <= req_s1;
            o_valid <= take;
            if (take) begin
                ack <= ~ack;
                o_data <= held;
            end
        end
    end
endmodule

module flex_port_device
    import flex_port_pkg::*;
(
    flex_port_if.dev_end link,
    input wire logic i_link_clk,
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_use_registers,
    input wire logic [1:0] i_reg_mode,
    input wire logic i_strap_full_duplex,
    input wire logic i_rx_valid,
    input wire logic [BUS_W-1:0] i_rx_a,
    input wire logic [BUS_W-1:0] i_rx_b,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [BUS_W-1:0] o_tx_a,
    output logic [BUS_W-1:0] o_tx_b
);
    logic rst_s1;
    logic link_rst_n;
    logic use_reg_s1;
    logic use_reg;
    logic [1:0] mode_s1;
    logic [1:0] reg_mode;
    logic fd_s1;
    logic strap_fd;
    logic phase;
    logic [PAIR_W-1:0] rx_hold;
    logic [PAIR_W-1:0] rx_cur;
    logic [BUS_W-1:0] upper_q;
    logic [BUS_W-1:0] upper_oe_q;
    logic [BUS_W-1:0] lower_q;
    logic [BUS_W-1:0] lower_oe_q;
    logic [BUS_W-1:0] tx_a_word;
    logic [PAIR_W-1:0] tx_pair;
    logic tx_push;
    logic rx_new;
    logic [PAIR_W-1:0] rx_new_pair;
    logic [PAIR_W-1:0] tx_out;

    // config levels come from the system side and are retimed into the link domain
    always_ff @(posedge i_link_clk) begin
        rst_s1 <= i_reset_n;
        link_rst_n <= rst_s1;
        use_reg_s1 <= i_use_registers;
        use_reg <= use_reg_s1;
        mode_s1 <= i_reg_mode;
        reg_mode <= mode_s1;
        fd_s1 <= i_strap_full_duplex;
        strap_fd <= fd_s1;
    end

    // straps can only reach wide, narrow or full duplex
    wire mode_t strap_mode = strap_fd ? full_duplex_mode :
        (link.width_or_sysclk_pin ? narrow_half_duplex_mode : wide_half_duplex_mode);
    wire mode_t mode = use_reg ? mode_t'(reg_mode) : strap_mode;
    wire is_fd = mode == full_duplex_mode;
    wire is_narrow = mode == narrow_half_duplex_mode;
    wire is_wide = mode == wide_half_duplex_mode;
    // direction is read live; the back end only flips it between transfers
    wire transmit = link.direction_or_sync_pin;
    wire rx_active = is_fd || !transmit;
    wire tx_active = is_fd || transmit;
    wire next_phase = ~phase;
    // a new pair is taken only at the start of a sample period
    wire [PAIR_W-1:0] sel_pair = next_phase ? rx_hold : rx_cur;
    wire [BUS_W-1:0] sel_a = sel_pair[PAIR_W-1:BUS_W];
    wire [BUS_W-1:0] sel_b = sel_pair[BUS_W-1:0];
    wire [BUS_W-1:0] inter_word = next_phase ? sel_a : sel_b;
    wire [BUS_W-1:0] next_upper_oe = !rx_active || is_fd ? BUS_NONE :
        (is_narrow ? BUS_MSB : BUS_ALL);
    wire [BUS_W-1:0] next_lower_oe = rx_active ? BUS_ALL : BUS_NONE;
    wire [BUS_W-1:0] next_upper = is_narrow ? {next_phase, 9'h000} : sel_b;
    wire [BUS_W-1:0] next_lower = (is_narrow || is_fd) ? inter_word : sel_a;
    wire tx_marker = is_fd ? link.direction_or_sync_pin : link.lower_bus[MARKER_BIT];

    assign link.upper_dev_o = upper_q;
    assign link.upper_dev_oe = upper_oe_q;
    assign link.lower_dev_o = lower_q;
    assign link.lower_dev_oe = lower_oe_q;
    assign link.path_clock_out_pin = phase;
    assign link.width_dev_o = phase;
    assign link.width_dev_oe = use_reg;
    assign o_tx_a = tx_out[PAIR_W-1:BUS_W];
    assign o_tx_b = tx_out[BUS_W-1:0];

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            phase <= PHASE_RESET;
            rx_hold <= PAIR_RESET;
            rx_cur <= PAIR_RESET;
            upper_q <= BUS_NONE;
            upper_oe_q <= BUS_NONE;
            lower_q <= BUS_NONE;
            lower_oe_q <= BUS_NONE;
        end else begin
            phase <= next_phase;
            if (rx_new) begin
                rx_hold <= rx_new_pair;
            end
            rx_cur <= sel_pair;
            upper_q <= next_upper;
            upper_oe_q <= next_upper_oe;
            lower_q <= next_lower;
            lower_oe_q <= next_lower_oe;
        end
    end

    // transmit capture: wide takes both buses once per period, others pair A then B
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            tx_a_word <= BUS_NONE;
            tx_pair <= PAIR_RESET;
            tx_push <= 1'b0;
        end else begin
            tx_push <= 1'b0;
            if (tx_active && is_wide && phase) begin
                tx_pair <= {link.upper_bus, link.lower_bus};
                tx_push <= 1'b1;
            end else if (tx_active && !is_wide && tx_marker) begin
                tx_a_word <= link.upper_bus;
            end else if (tx_active && !is_wide) begin
                tx_pair <= {tx_a_word, link.upper_bus};
                tx_push <= 1'b1;
            end
        end
    end

    // pairs wait on o_rx_ready while the crossing is busy: the link side repeats the last pair until a new one lands
    word_mailbox rx_box (
        .i_src_clk(i_sys_clk),
        .i_src_rst_n(i_reset_n),
        .i_valid(i_rx_valid),
        .i_data({i_rx_a, i_rx_b}),
        .o_ready(o_rx_ready),
        .i_dst_clk(i_link_clk),
        .i_dst_rst_n(link_rst_n),
        .o_valid(rx_new),
        .o_data(rx_new_pair)
    );

    word_mailbox tx_box (
        .i_src_clk(i_link_clk),
        .i_src_rst_n(link_rst_n),
        .i_valid(tx_push),
        .i_data(tx_pair),
        .o_ready(),
        .i_dst_clk(i_sys_clk),
        .i_dst_rst_n(i_reset_n),
        .o_valid(o_tx_valid),
        .o_data(tx_out)
    );
endmodule

/* flex_port_host.sv */
// back-end end of the dual-bus data port
`timescale 1ns/1ns
module flex_port_host
    import flex_port_pkg::*;
(
    flex_port_if.host_end link,
    input wire logic i_link_clk,
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_use_registers,
    input wire logic [1:0] i_mode,
    input wire logic i_transmit,
    input wire logic i_tx_valid,
    input wire logic [BUS_W-1:0] i_tx_a,
    input wire logic [BUS_W-1:0] i_tx_b,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [BUS_W-1:0] o_rx_a,
    output logic [BUS_W-1:0] o_rx_b
);
    logic rst_s1;
    logic link_rst_n;
    logic use_reg_s1;
    logic use_reg;
    logic [1:0] mode_s1;
    logic [1:0] mode_code;
    logic xmit_s1;
    logic transmit;
    logic [PAIR_W-1:0] tx_hold;
    logic [PAIR_W-1:0] tx_cur;
    logic [BUS_W-1:0] upper_q;
    logic [BUS_W-1:0] upper_oe_q;
    logic [BUS_W-1:0] lower_q;
    logic [BUS_W-1:0] lower_oe_q;
    logic dir_q;
    logic width_q;
    logic width_oe_q;
    logic [BUS_W-1:0] rx_a_word;
    logic [PAIR_W-1:0] rx_pair;
    logic rx_push;
    logic tx_new;
    logic [PAIR_W-1:0] tx_new_pair;
    logic [PAIR_W-1:0] rx_out;

    always_ff @(posedge i_link_clk) begin
        rst_s1 <= i_reset_n;
        link_rst_n <= rst_s1;
        use_reg_s1 <= i_use_registers;
        use_reg <= use_reg_s1;
        mode_s1 <= i_mode;
        mode_code <= mode_s1;
        xmit_s1 <= i_transmit;
        transmit <= xmit_s1;
    end

    wire mode_t mode = mode_t'(mode_code);
    wire is_fd = mode == full_duplex_mode;
    wire is_narrow = mode == narrow_half_duplex_mode;
    wire is_wide = mode == wide_half_duplex_mode;
    wire tx_active = is_fd || transmit;
    wire rx_active = is_fd || !transmit;
    // half duplex: drive only after the converter has seen the new direction for an edge,
    // so the two ends never drive one bus in the same cycle
    wire drive_ok = tx_active && (is_fd || dir_q);
    wire pclk = link.path_clock_out_pin;
    // our word lands one edge later, in the opposite clock phase
    wire next_marker = ~pclk;
    wire [PAIR_W-1:0] sel_pair = next_marker ? tx_hold : tx_cur;
    wire [BUS_W-1:0] sel_a = sel_pair[PAIR_W-1:BUS_W];
    wire [BUS_W-1:0] sel_b = sel_pair[BUS_W-1:0];
    wire [BUS_W-1:0] next_upper = (is_wide || next_marker) ? sel_a : sel_b;
    wire [BUS_W-1:0] next_upper_oe = drive_ok ? BUS_ALL : BUS_NONE;
    wire [BUS_W-1:0] next_lower = is_wide ? sel_b : {next_marker, 9'h000};
    wire [BUS_W-1:0] next_lower_oe = !drive_ok || is_fd ? BUS_NONE :
        (is_wide ? BUS_ALL : BUS_MSB);
    wire next_dir = is_fd ? next_marker : transmit;
    wire rx_marker = is_fd ? pclk : link.upper_bus[MARKER_BIT];

    assign link.upper_host_o = upper_q;
    assign link.upper_host_oe = upper_oe_q;
    assign link.lower_host_o = lower_q;
    assign link.lower_host_oe = lower_oe_q;
    assign link.direction_or_sync_pin = dir_q;
    assign link.width_host_o = width_q;
    assign link.width_host_oe = width_oe_q;
    assign o_rx_a = rx_out[PAIR_W-1:BUS_W];
    assign o_rx_b = rx_out[BUS_W-1:0];

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            tx_hold <= PAIR_RESET;
            tx_cur <= PAIR_RESET;
            upper_q <= BUS_NONE;
            upper_oe_q <= BUS_NONE;
            lower_q <= BUS_NONE;
            lower_oe_q <= BUS_NONE;
            dir_q <= 1'b0;
            width_q <= 1'b0;
            width_oe_q <= 1'b0;
        end else begin
            if (tx_new) begin
                tx_hold <= tx_new_pair;
            end
            tx_cur <= sel_pair;
            upper_q <= next_upper;
            upper_oe_q <= next_upper_oe;
            lower_q <= next_lower;
            lower_oe_q <= next_lower_oe;
            dir_q <= next_dir;
            width_q <= is_narrow;
            width_oe_q <= !use_reg;
        end
    end

    // receive capture: wide and legacy read both buses once per period
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            rx_a_word <= BUS_NONE;
            rx_pair <= PAIR_RESET;
            rx_push <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            if (rx_active && !is_narrow && !is_fd && pclk) begin
                rx_pair <= {link.lower_bus, link.upper_bus};
                rx_push <= 1'b1;
            end else if (rx_active && (is_narrow || is_fd) && rx_marker) begin
                rx_a_word <= link.lower_bus;
            end else if (rx_active && (is_narrow || is_fd) && !pclk) begin
                rx_pair <= {rx_a_word, link.lower_bus};
                rx_push <= 1'b1;
            end
        end
    end

    word_mailbox tx_box (
        .i_src_clk(i_sys_clk),
        .i_src_rst_n(i_reset_n),
        .i_valid(i_tx_valid),
        .i_data({i_tx_a, i_tx_b}),
        .o_ready(o_tx_ready),
        .i_dst_clk(i_link_clk),
        .i_dst_rst_n(link_rst_n),
        .o_valid(tx_new),
        .o_data(tx_new_pair)
    );

    word_mailbox rx_box (
        .i_src_clk(i_link_clk),
        .i_src_rst_n(link_rst_n),
        .i_valid(rx_push),
        .i_data(rx_pair),
        .o_ready(),
        .i_dst_clk(i_sys_clk),
        .i_dst_rst_n(i_reset_n),
        .o_valid(o_rx_valid),
        .o_data(rx_out)
    );
endmodule

/* flex_port_if.sv */
// pins between the converter port and the digital back end
`timescale 1ns/1ns
interface flex_port_if;
    import flex_port_pkg::*;
    logic [BUS_W-1:0] upper_dev_o;
    logic [BUS_W-1:0] upper_dev_oe;
    logic [BUS_W-1:0] upper_host_o;
    logic [BUS_W-1:0] upper_host_oe;
    logic [BUS_W-1:0] lower_dev_o;
    logic [BUS_W-1:0] lower_dev_oe;
    logic [BUS_W-1:0] lower_host_o;
    logic [BUS_W-1:0] lower_host_oe;
    logic direction_or_sync_pin;
    logic width_dev_o;
    logic width_dev_oe;
    logic width_host_o;
    logic width_host_oe;
    logic path_clock_out_pin;
    logic [BUS_W-1:0] upper_bus;
    logic [BUS_W-1:0] lower_bus;
    logic width_or_sysclk_pin;

    // undriven bits read low instead of floating
    assign upper_bus = (upper_dev_oe & upper_dev_o) |
        (~upper_dev_oe & upper_host_oe & upper_host_o);
    assign lower_bus = (lower_dev_oe & lower_dev_o) |
        (~lower_dev_oe & lower_host_oe & lower_host_o);
    assign width_or_sysclk_pin = width_dev_oe ? width_dev_o : (width_host_oe & width_host_o);

    modport dev_end (
        output upper_dev_o, upper_dev_oe, lower_dev_o, lower_dev_oe,
        output width_dev_o, width_dev_oe, path_clock_out_pin,
        input upper_bus, lower_bus, width_or_sysclk_pin, direction_or_sync_pin
    );
    modport host_end (
        output upper_host_o, upper_host_oe, lower_host_o, lower_host_oe,
        output width_host_o, width_host_oe, direction_or_sync_pin,
        input upper_bus, lower_bus, width_or_sysclk_pin, path_clock_out_pin
    );
endinterface

/* flex_port_pkg.sv */
// shared constants and types for the dual-bus data port
package flex_port_pkg;
    localparam int BUS_W = 10;
    localparam int MARKER_BIT = 9;
    localparam int PAIR_W = 2 * BUS_W;
    typedef enum logic [1:0] {
        wide_half_duplex_mode,
        narrow_half_duplex_mode,
        full_duplex_mode,
        legacy_mode
    } mode_t;
    localparam logic [BUS_W-1:0] BUS_ALL = 10'h3ff;
    localparam logic [BUS_W-1:0] BUS_MSB = 10'h200;
    localparam logic [BUS_W-1:0] BUS_NONE = 10'h000;
    localparam logic [PAIR_W-1:0] PAIR_RESET = 20'h00000;
    localparam logic PHASE_RESET = 1'b0;
    localparam logic [1:0] MODE_CODE_RESET = 2'h0;
endpackage

/* tb_flexible_dual_bus_data_port.sv */
// end-to-end bench: converter end facing back end across the pin interface
`timescale 1ns/1ns
module tb_flexible_dual_bus_data_port
    import flex_port_pkg::*;
;
    typedef struct packed {
        logic reg_cfg;
        logic [1:0] mode;
        logic tx;
        logic [BUS_W-1:0] a;
        logic [BUS_W-1:0] b;
    } row_t;
    logic i_sys_clk = 1'b0;
    logic i_link_clk = 1'b1;
    logic i_reset_n = 1'b0;
    logic use_reg = 1'b0;
    logic strap_fd = 1'b0;
    logic transmit = 1'b0;
    logic [1:0] dev_mode = 2'h0;
    logic [1:0] host_mode = 2'h0;
    logic rx_valid = 1'b0;
    logic tx_valid = 1'b0;
    logic [BUS_W-1:0] rx_a = BUS_NONE;
    logic [BUS_W-1:0] rx_b = BUS_NONE;
    logic [BUS_W-1:0] tx_a = BUS_NONE;
    logic [BUS_W-1:0] tx_b = BUS_NONE;
    logic rx_ready, dev_tx_valid, tx_ready, host_rx_valid;
    logic [BUS_W-1:0] dev_tx_a, dev_tx_b, host_rx_a, host_rx_b;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    row_t rows [9] = '{
        '{1'b0, 2'h0, 1'b0, 10'h155, 10'h0aa}, '{1'b0, 2'h0, 1'b1, 10'h0c3, 10'h03c},
        '{1'b0, 2'h1, 1'b0, 10'h111, 10'h022}, '{1'b0, 2'h1, 1'b1, 10'h1e1, 10'h01e},
        '{1'b0, 2'h2, 1'b1, 10'h2a5, 10'h05a}, '{1'b1, 2'h3, 1'b0, 10'h123, 10'h321},
        '{1'b1, 2'h3, 1'b1, 10'h0f0, 10'h10f}, '{1'b1, 2'h1, 1'b0, 10'h2dd, 10'h0bb},
        '{1'b1, 2'h0, 1'b1, 10'h3ff, 10'h001}};

    flex_port_if link();
    flex_port_device flex_port_device_i(.link(link), .i_link_clk(i_link_clk),
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_use_registers(use_reg),
        .i_reg_mode(dev_mode), .i_strap_full_duplex(strap_fd), .i_rx_valid(rx_valid),
        .i_rx_a(rx_a), .i_rx_b(rx_b), .o_rx_ready(rx_ready), .o_tx_valid(dev_tx_valid),
        .o_tx_a(dev_tx_a), .o_tx_b(dev_tx_b));
    flex_port_host flex_port_host_i(.link(link), .i_link_clk(i_link_clk),
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_use_registers(use_reg),
        .i_mode(host_mode), .i_transmit(transmit), .i_tx_valid(tx_valid), .i_tx_a(tx_a),
        .i_tx_b(tx_b), .o_tx_ready(tx_ready), .o_rx_valid(host_rx_valid),
        .o_rx_a(host_rx_a), .o_rx_b(host_rx_b));
    flex_port_asserts flex_port_asserts_i(.i_link_clk(i_link_clk), .i_reset_n(i_reset_n),
        .upper_dev_oe(link.upper_dev_oe), .lower_dev_oe(link.lower_dev_oe),
        .upper_host_oe(link.upper_host_oe), .lower_host_oe(link.lower_host_oe),
        .upper_bus(link.upper_bus), .lower_bus(link.lower_bus),
        .width_dev_o(link.width_dev_o), .width_dev_oe(link.width_dev_oe),
        .width_host_oe(link.width_host_oe), .path_clock_out_pin(link.path_clock_out_pin));

    always #25 i_sys_clk = ~i_sys_clk;
    // link clock starts high so its rising edges never meet a system rising edge
    always #3 i_link_clk = ~i_link_clk;

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [PAIR_W-1:0] seen, input logic [PAIR_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic dir, input logic [BUS_W-1:0] a, input logic [BUS_W-1:0] b);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        if (dir) {tx_valid, tx_a, tx_b} <= {1'b1, a, b};
        else {rx_valid, rx_a, rx_b} <= {1'b1, a, b};
        // ready is looked at half a cycle before the edge that takes the pair
        do begin
            @(negedge i_sys_clk);
            n++;
        end while ((dir ? tx_ready : rx_ready) !== 1'b1 && n < 200);
        if ((dir ? tx_ready : rx_ready) !== 1'b1) miscompares++;
        @(posedge i_sys_clk);
        if (dir) tx_valid <= 1'b0;
        else rx_valid <= 1'b0;
    endtask

    // zero pairs stream out before ours arrives, so skip them
    task automatic expect_pair(input logic dir, input logic [PAIR_W-1:0] exp);
        int n;
        logic [PAIR_W-1:0] got;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            got = dir ? {dev_tx_a, dev_tx_b} : {host_rx_a, host_rx_b};
            n++;
        end while (!((dir ? dev_tx_valid : host_rx_valid) === 1'b1 && got != 0) && n < 400);
        check(got, exp);
    endtask

    task automatic wire_check(input row_t r);
        int n;
        logic hit;
        logic half;
        half = r.tx && r.mode != 2'h2;
        hit = 1'b0;
        for (n = 0; n < 400 && !hit; n++) begin
            @(negedge i_link_clk);
            if (half) hit = link.upper_bus != BUS_NONE && (r.mode == 2'h0 || link.lower_bus[9]);
            else hit = link.path_clock_out_pin && link.lower_bus != BUS_NONE;
        end
        if (half && r.mode == 2'h0) check({link.upper_bus, link.lower_bus}, {r.a, r.b});
        else if (half) check({link.upper_bus, link.lower_bus}, {r.a, BUS_MSB});
        else if (r.mode == 2'h1) check({link.upper_bus, link.lower_bus}, {BUS_MSB, r.a});
        else if (r.mode == 2'h2) check({BUS_NONE, link.lower_bus}, {BUS_NONE, r.a});
        else check({link.upper_bus, link.lower_bus}, {r.b, r.a});
    endtask

    task automatic run_row(input row_t r, input logic [1:0] dmode);
        logic p;
        @(posedge i_sys_clk);
        {i_reset_n, use_reg, dev_mode, host_mode, strap_fd, transmit} <=
            {1'b0, r.reg_cfg, dmode, r.mode, r.mode == 2'h2, r.tx};
        repeat (4) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        fork
            if (!r.tx || r.mode == 2'h2) begin
                send(1'b0, r.a, r.b);
                expect_pair(1'b0, {r.a, r.b});
            end
            if (r.tx) begin
                send(1'b1, r.a, r.b);
                expect_pair(1'b1, {r.a, r.b});
            end
            wire_check(r);
        join
        @(negedge i_link_clk);
        p = link.width_or_sysclk_pin;
        @(negedge i_link_clk);
        if (r.reg_cfg) check({19'h0, p ^ link.width_or_sysclk_pin}, 20'h1);
        else check({19'h0, p}, {19'h0, r.mode == 2'h1});
        $display("test done: cfg %0d mode %0d tx %0d", r.reg_cfg, r.mode, r.tx);
    endtask

    initial begin
        foreach (rows[i]) run_row(rows[i], rows[i].mode);
        // register mode field asks for legacy, but straps must keep wide transfer
        run_row(rows[1], 2'h3);
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check({link.upper_bus, link.lower_bus}, PAIR_RESET);
        check({19'h0, link.path_clock_out_pin}, 20'h0);
        @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        // the link side stays in reset for two more link edges after release
        repeat (2) begin
            @(negedge i_link_clk);
            check({19'h0, link.path_clock_out_pin}, 20'h0);
            check({link.upper_bus, link.lower_bus}, PAIR_RESET);
        end
        $display("test done: mid-run reset");
        tally_and_finish();
    end
endmodule
